//--- logic/gpio_mux_cfg.svh
`ifndef GPIO_MUX_CFG_SVH
`define GPIO_MUX_CFG_SVH

// Register offsets (byte addresses)
`define GPIO_OFS_OUT 8'h00
`define GPIO_OFS_DIR 8'h04
`define GPIO_OFS_ALT 8'h08
`define GPIO_OFS_IN 8'h0c
`define GPIO_OFS_STAT 8'h10
`define GPIO_OFS_CLR 8'h14
`define GPIO_OFS_EN 8'h18
`define GPIO_OFS_FUNC 8'h1c
`define GPIO_OFS_HP 8'h20

// Pins with an alternate function
`define GPIO_PIN_P2RST 0
`define GPIO_PIN_P4RST 1
`define GPIO_PIN_EXP0 2
`define GPIO_PIN_EXP2 4
`define GPIO_PIN_GPE 7

// Bits of the function control register
`define GPIO_FUNC_P2RST 0
`define GPIO_FUNC_P4RST 1
`define GPIO_FUNC_GPE 2

// Status bits above the per-pin change bits
`define GPIO_STAT_EXP0 0
`define GPIO_STAT_EXP2 1

// Reset values
`define GPIO_RST_OUT 32'h0000_0000
`define GPIO_RST_DIR 32'h0000_0000
`define GPIO_RST_ALT 32'h0000_0000
`define GPIO_RST_FUNC 3'h0

`endif

//--- logic/gpio_mux_pkg.sv
package gpio_mux_pkg;

  // One register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_req_type;

  // Alternate-function selection loaded from the configuration EEPROM
  typedef struct packed {
    logic valid;
    logic [31:0] alt_sel;
  } cfg_load_type;

  // Hot-plug input read request handshake
  typedef enum logic [1:0] {
    HP_IDLE = 2'b00,
    HP_REQ = 2'b01,
    HP_WAIT = 2'b10
  } hp_state_type;

endpackage

//--- logic/gpio_alt_function_mux.sv
`timescale 1ns/1ns
`include "gpio_mux_cfg.svh"

// How it works
// RL1 - Any pin whose alternate function is off acts as a software bit I/O with its own output and direction bits.
// RL2 - A per-pin select bit decides whether the alternate function or the bit I/O owns the pin.
// RL3 - Names ending in n are active low and everything else is active high.
// RL4 - Pin 0 with its alternate function selected drives the active-low reset of downstream port 2.
// RL5 - Pin 1 with its alternate function selected drives the active-low reset of downstream port 4.
// RL6 - Pin 2 with its alternate function selected is an input taking the active-low interrupt of expander 0; the code ignores it while dir_q[2] is 1.
// RL7 - Pin 4 with its alternate function selected is an input taking the active-low interrupt of expander 2; the code ignores it while dir_q[4] is 1.
// RL8 - Pin 7 with its alternate function selected drives the active-low general purpose event.
// RL9 - Software sets the direction of every pin on its own, input or output; with alt_q set the code forces pins 0, 1, 7 out and 2, 4 in.
// RL10 - The alternate selection is written by software over the register port or loaded from the EEPROM.
// RL11 - An asserted expander interrupt makes the device request a read of all hot-plug inputs.
// RL12 - Every pin input passes a two-stage synchroniser before any logic uses it.
// RL13 - After reset every pin is an input with its alternate function off.

module gpio_alt_function_mux #(
  parameter int N_PINS = 11
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // Register port
  input wire gpio_mux_pkg::reg_req_type i_reg_req,
  output logic [31:0] o_rdata,
  // Configuration load
  input wire gpio_mux_pkg::cfg_load_type i_cfg_load,
  // Pins
  input wire logic [N_PINS-1:0] i_pin,
  output logic [N_PINS-1:0] o_pin,
  output logic [N_PINS-1:0] o_pin_oe_n,
  // Hot-plug read request to the master SMBus engine
  output logic o_hp_read_req,
  input wire logic i_hp_read_done,
  // Interrupt
  output logic o_irq
);

  localparam int N_STAT = N_PINS + 2;

  if (N_PINS < 8 || N_PINS > 30) begin : g_bad_pins
    $error("N_PINS must lie between 8 and 30");
  end

  // ****************************************
  // Registers
  // ****************************************
  logic [N_PINS-1:0] out_q;
  logic [N_PINS-1:0] dir_q;
  logic [N_PINS-1:0] alt_q;
  logic [2:0] func_q;
  logic [N_STAT-1:0] stat_q;
  logic [N_STAT-1:0] en_q;
  logic [N_PINS-1:0] sync1_q;
  logic [N_PINS-1:0] sync2_q;
  logic [N_PINS-1:0] prev_q;
  gpio_mux_pkg::hp_state_type hp_q;
  logic exp0_on;
  logic exp2_on;
  logic exp0_fall;
  logic exp2_fall;
  logic [N_PINS-1:0] gp_change;
  logic [N_STAT-1:0] events;
  logic wr_en;
  logic wr_clr;
  logic [N_STAT-1:0] clr_bits;

  assign wr_en = i_reg_req.wr && i_reg_req.addr == `GPIO_OFS_EN;
  assign wr_clr = i_reg_req.wr && i_reg_req.addr == `GPIO_OFS_CLR;
  assign clr_bits = wr_clr ? i_reg_req.wdata[N_STAT-1:0] : '0;

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      out_q <= N_PINS'(`GPIO_RST_OUT);
    end else if (i_reg_req.wr && i_reg_req.addr == `GPIO_OFS_OUT) begin
      out_q <= i_reg_req.wdata[N_PINS-1:0]; // RL1
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      dir_q <= N_PINS'(`GPIO_RST_DIR); // RL13
    end else if (i_reg_req.wr && i_reg_req.addr == `GPIO_OFS_DIR) begin
      dir_q <= i_reg_req.wdata[N_PINS-1:0]; // RL9
    end
  end

  // Software write wins over a simultaneous EEPROM load
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      alt_q <= N_PINS'(`GPIO_RST_ALT); // RL13
    end else if (i_reg_req.wr && i_reg_req.addr == `GPIO_OFS_ALT) begin
      alt_q <= i_reg_req.wdata[N_PINS-1:0]; // RL10
    end else if (i_cfg_load.valid) begin
      alt_q <= i_cfg_load.alt_sel[N_PINS-1:0]; // RL10
    end
  end

  // Function control: 1 asserts the alternate output
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      func_q <= `GPIO_RST_FUNC;
    end else if (i_reg_req.wr && i_reg_req.addr == `GPIO_OFS_FUNC) begin
      func_q <= i_reg_req.wdata[2:0];
    end
  end

  // ****************************************
  // Input synchroniser and events
  // ****************************************
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q <= '0;
    end else begin
      sync1_q <= i_pin; // RL12
      sync2_q <= sync1_q; // RL12
      prev_q <= sync2_q;
    end
  end

  assign exp0_on = alt_q[`GPIO_PIN_EXP0] && !dir_q[`GPIO_PIN_EXP0];
  assign exp2_on = alt_q[`GPIO_PIN_EXP2] && !dir_q[`GPIO_PIN_EXP2];
  assign exp0_fall = exp0_on && prev_q[`GPIO_PIN_EXP0] && !sync2_q[`GPIO_PIN_EXP0]; // RL6 RL3
  assign exp2_fall = exp2_on && prev_q[`GPIO_PIN_EXP2] && !sync2_q[`GPIO_PIN_EXP2]; // RL7 RL3
  assign gp_change = (sync2_q ^ prev_q) & ~dir_q & ~alt_q;
  assign events = {exp2_fall, exp0_fall, gp_change};

  // Set wins over clear
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      stat_q <= '0;
    end else begin
      stat_q <= (stat_q & ~clr_bits) | events;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      en_q <= '0;
    end else if (wr_en) begin
      en_q <= i_reg_req.wdata[N_STAT-1:0];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(((stat_q & ~clr_bits) | events) & en_q);
    end
  end

  // ****************************************
  // Hot-plug read request
  // ****************************************
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      hp_q <= gpio_mux_pkg::HP_IDLE;
    end else begin
      case (hp_q)
        gpio_mux_pkg::HP_IDLE: begin
          if (exp0_fall || exp2_fall) begin
            hp_q <= gpio_mux_pkg::HP_REQ; // RL11
          end
        end
        gpio_mux_pkg::HP_REQ: begin
          if (i_hp_read_done) begin
            hp_q <= (exp0_fall || exp2_fall) ? gpio_mux_pkg::HP_REQ : gpio_mux_pkg::HP_IDLE;
          end else if (exp0_fall || exp2_fall) begin
            hp_q <= gpio_mux_pkg::HP_WAIT;
          end
        end
        gpio_mux_pkg::HP_WAIT: begin
          // A change arrived during a read: read again afterwards
          if (i_hp_read_done) begin
            hp_q <= gpio_mux_pkg::HP_REQ; // RL11
          end
        end
        default: begin
          hp_q <= gpio_mux_pkg::HP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      o_hp_read_req <= 1'b0;
    end else begin
      case (hp_q)
        gpio_mux_pkg::HP_IDLE: o_hp_read_req <= exp0_fall || exp2_fall;
        gpio_mux_pkg::HP_REQ: o_hp_read_req <= !i_hp_read_done || exp0_fall || exp2_fall;
        gpio_mux_pkg::HP_WAIT: o_hp_read_req <= 1'b1;
        default: o_hp_read_req <= 1'b0;
      endcase
    end
  end

  // ****************************************
  // Pin drive
  // ****************************************
  for (genvar p = 0; p < N_PINS; p++) begin : g_pin
    logic drv;
    logic val;
    always_comb begin
      drv = dir_q[p]; // RL1 RL9
      val = out_q[p];
      if (alt_q[p]) begin // RL2
        case (p)
          `GPIO_PIN_P2RST: begin
            drv = 1'b1;
            val = !func_q[`GPIO_FUNC_P2RST]; // RL4 RL3
          end
          `GPIO_PIN_P4RST: begin
            drv = 1'b1;
            val = !func_q[`GPIO_FUNC_P4RST]; // RL5 RL3
          end
          `GPIO_PIN_EXP0, `GPIO_PIN_EXP2: begin
            drv = 1'b0; // RL6 RL7
            val = 1'b0;
          end
          `GPIO_PIN_GPE: begin
            drv = 1'b1;
            val = !func_q[`GPIO_FUNC_GPE]; // RL8 RL3
          end
          default: begin
            drv = dir_q[p];
            val = out_q[p];
          end
        endcase
      end
    end
    always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
        o_pin[p] <= 1'b0;
        o_pin_oe_n[p] <= 1'b1; // RL13
      end else begin
        o_pin[p] <= val;
        o_pin_oe_n[p] <= !drv;
      end
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      o_rdata <= '0;
    end else if (i_reg_req.rd) begin
      case (i_reg_req.addr)
        `GPIO_OFS_OUT: o_rdata <= 32'(out_q);
        `GPIO_OFS_DIR: o_rdata <= 32'(dir_q);
        `GPIO_OFS_ALT: o_rdata <= 32'(alt_q);
        `GPIO_OFS_IN: o_rdata <= 32'(sync2_q);
        `GPIO_OFS_STAT: o_rdata <= 32'(stat_q);
        `GPIO_OFS_EN: o_rdata <= 32'(en_q);
        `GPIO_OFS_FUNC: o_rdata <= 32'(func_q);
        `GPIO_OFS_HP: o_rdata <= {30'h0, sync2_q[`GPIO_PIN_EXP2], sync2_q[`GPIO_PIN_EXP0]};
        default: o_rdata <= 32'h0000_0000;
      endcase
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end

endmodule

//--- tb/gpio_alt_function_mux_sva.sv
`timescale 1ns/1ns
module gpio_mux_chk #(
  parameter int N_PINS = 11
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire gpio_mux_pkg::reg_req_type i_reg_req,
  input wire logic [31:0] o_rdata,
  input wire gpio_mux_pkg::cfg_load_type i_cfg_load,
  input wire logic [N_PINS-1:0] i_pin,
  input wire logic [N_PINS-1:0] o_pin,
  input wire logic [N_PINS-1:0] o_pin_oe_n,
  input wire logic o_hp_read_req,
  input wire logic i_hp_read_done,
  input wire logic o_irq
);
  // Pins with no alternate function
  localparam logic [10:0] PLAIN = 11'h768;
  wire logic w = i_reg_req.wr;
  wire logic r = i_reg_req.rd;
  wire logic [7:0] ad = i_reg_req.addr;
  wire logic [31:0] wd = i_reg_req.wdata;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  a_reset_inputs: assert property (disable iff (1'b0) !i_reset_n |=> &o_pin_oe_n && !o_irq && !o_hp_read_req)
    else $error("pins not idle after reset");
  a_refused_read: assert property (r && (ad == 8'h14 || ad > 8'h20) |=> o_rdata == 32'h0)
    else $error("refused read not zero");
  a_in_sync: assert property (r && ad == 8'h0c && $stable(i_pin) && $past(i_pin) == $past(i_pin, 2) |=>
    o_rdata[N_PINS-1:0] == $past(i_pin)) else $error("input read wrong");
  a_dir_plain: assert property (w && ad == 8'h04 |-> ##2 (o_pin_oe_n & PLAIN) == (~$past(wd[10:0], 2) & PLAIN))
    else $error("direction not applied");
  a_out_plain: assert property (w && ad == 8'h00 |-> ##2 (o_pin & PLAIN) == ($past(wd[10:0], 2) & PLAIN))
    else $error("output not applied");
  a_irq_masked: assert property (w && ad == 8'h18 && wd == 32'h0 ##1 !(w && ad == 8'h18) |=> !o_irq)
    else $error("masked irq high");
  a_hp_hold: assert property (o_hp_read_req && !i_hp_read_done |=> o_hp_read_req)
    else $error("read request dropped");
  a_hp_cause: assert property ($rose(o_hp_read_req) |-> !$past(i_pin[2], 2) || !$past(i_pin[4], 2))
    else $error("read request without interrupt");
  c_irq: cover property ($rose(o_irq));
  c_hp_done: cover property (o_hp_read_req && i_hp_read_done);
  c_load: cover property (i_cfg_load.valid);
endmodule

bind gpio_alt_function_mux gpio_mux_chk #(.N_PINS(N_PINS)) u_gpio_mux_chk (.i_clk_sys(i_clk_sys),
  .i_reset_n(i_reset_n), .i_reg_req(i_reg_req), .o_rdata(o_rdata), .i_cfg_load(i_cfg_load), .i_pin(i_pin),
  .o_pin(o_pin), .o_pin_oe_n(o_pin_oe_n), .o_hp_read_req(o_hp_read_req), .i_hp_read_done(i_hp_read_done),
  .o_irq(o_irq));

//--- tb/hp_expander_model.sv
`timescale 1ns/1ns
module hp_expander_model (
  input wire logic i_clk_sys,
  input wire logic i_read_req,
  input wire logic [1:0] i_change,
  input wire logic [3:0] i_lat,
  output logic [1:0] o_irq_n,
  output logic o_done
);
  logic [3:0] wait_q;
  initial begin
    o_irq_n = 2'h3;
    o_done = 1'b0;
    wait_q = 4'h0;
  end
  // Interrupt held low until the read of all inputs finishes
  always @(posedge i_clk_sys) begin
    o_done <= 1'b0;
    if (i_read_req && !o_done && wait_q == i_lat) begin
      o_done <= 1'b1;
      o_irq_n <= 2'h3;
      wait_q <= 4'h0;
    end else begin
      wait_q <= wait_q + {3'h0, i_read_req && !o_done};
      o_irq_n <= o_irq_n & ~i_change;
    end
  end
endmodule

//--- tb/tb_gpio_alt_function_mux.sv
`timescale 1ns/1ns
module tb_gpio_alt_function_mux;
  logic i_clk_sys = 1'b0;
  logic i_reset_n = 1'b0;
  gpio_mux_pkg::reg_req_type req = '0;
  gpio_mux_pkg::cfg_load_type load = '0;
  logic [31:0] rdata;
  logic [10:0] pin_w, o_pin, oe_n;
  logic [10:0] ext = 11'h300;
  logic [1:0] chg = 2'h0;
  logic [1:0] irq_n;
  logic [3:0] lat = 4'h1;
  logic hp_req, hp_done, irq;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #4 i_clk_sys = ~i_clk_sys;
  assign pin_w = (o_pin & ~oe_n) | ({ext[10:5], irq_n[1], ext[3], irq_n[0], ext[1:0]} & oe_n);
  gpio_alt_function_mux u_gpio_alt_function_mux (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_reg_req(req),
    .o_rdata(rdata), .i_cfg_load(load), .i_pin(pin_w), .o_pin(o_pin), .o_pin_oe_n(oe_n),
    .o_hp_read_req(hp_req), .i_hp_read_done(hp_done), .o_irq(irq));
  hp_expander_model u_hp_expander_model (.i_clk_sys(i_clk_sys), .i_read_req(hp_req), .i_change(chg),
    .i_lat(lat), .o_irq_n(irq_n), .o_done(hp_done));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge i_clk_sys);
    req.wr <= 1'b0;
    @(posedge i_clk_sys);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clk_sys);
    req <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge i_clk_sys);
    req.rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic event_on(input int e);
    @(posedge i_clk_sys);
    chg <= 2'(1 << e);
    @(posedge i_clk_sys);
    chg <= 2'h0;
    for (int k = 0; k < 20 && hp_req !== 1'b1; k++) @(posedge i_clk_sys);
    #1 chk({31'h0, hp_req}, 32'h1);
    rd(8'h10, 32'h800 << e);
  endtask
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      summarize();
    end
  end
  initial begin
    repeat (3) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    #1 chk({21'h0, oe_n}, 32'h7ff);
    rd(8'h08, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h40, 32'h0);
    $display("reset test done");
    wr(8'h00, 32'h555);
    wr(8'h04, 32'h7ff);
    chk({21'h0, o_pin}, 32'h555);
    chk({21'h0, oe_n}, 32'h0);
    wr(8'h04, 32'h0f0);
    chk({21'h0, oe_n}, 32'h70f);
    repeat (3) @(posedge i_clk_sys);
    rd(8'h0c, 32'h354);
    $display("bit io test done");
    wr(8'h04, 32'h0);
    wr(8'h08, 32'h083);
    for (int f = 0; f < 8; f++) begin
      wr(8'h1c, 32'(f));
      chk({26'h0, o_pin[7], o_pin[1:0], oe_n[7], oe_n[1:0]}, {26'h0, ~f[2], ~f[1], ~f[0], 3'h0});
    end
    wr(8'h08, 32'h0);
    chk({21'h0, oe_n}, 32'h7ff);
    @(posedge i_clk_sys);
    load <= '{1'b1, 32'h083};
    @(posedge i_clk_sys);
    load.valid <= 1'b0;
    @(posedge i_clk_sys);
    #1 chk({21'h0, oe_n}, 32'h77c);
    $display("alternate test done");
    wr(8'h08, 32'h014);
    wr(8'h14, 32'h1fff);
    wr(8'h18, 32'h1800);
    rd(8'h10, 32'h0);
    for (int e = 0; e < 2; e++) begin
      lat <= e ? 4'h9 : 4'h1;
      event_on(e);
      chk({31'h0, irq}, 32'h1);
      repeat (14) @(posedge i_clk_sys);
      #1 chk({31'h0, hp_req}, 32'h0);
      rd(8'h20, 32'h3);
      wr(8'h14, 32'h800 << e);
      @(posedge i_clk_sys);
      #1 chk({31'h0, irq}, 32'h0);
    end
    wr(8'h18, 32'h0);
    event_on(0);
    chk({31'h0, irq}, 32'h0);
    wr(8'h18, 32'h800);
    @(posedge i_clk_sys);
    #1 chk({31'h0, irq}, 32'h1);
    $display("expander test done");
    summarize();
  end
endmodule
